//--- design/cos_defs.svh
// Offsets, field positions, reset values and timing counts of the control output stage
`ifndef COS_DEFS_SVH
`define COS_DEFS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define COS_CTRL_OFS    12'h000
`define COS_CYCLE_OFS   12'h004
`define COS_HIGH_OFS    12'h008
`define COS_LOW_OFS     12'h00C
`define COS_SLEW_OFS    12'h010
`define COS_PRESET_OFS  12'h014
`define COS_STATUS_OFS  12'h018
// ****************************************************************
// Control and status register fields
// ****************************************************************
`define COS_CTRL_DIR    0
`define COS_CTRL_SCR    1
`define COS_CTRL_LAMP   2
`define COS_CTRL_BSEL   4
`define COS_CTRL_ROUTE  6
`define COS_STAT_PULSE  16
`define COS_STAT_FAULT  17
// ****************************************************************
// Reset values and ranges (MV in 0.1 % steps)
// ****************************************************************
`define COS_CTRL_RST    8'h10
`define COS_CYCLE_RST   8'h02
`define COS_HIGH_RST    12'sh3E8
`define COS_LOW_RST     12'sh000
`define COS_SLEW_RST    11'h000
`define COS_PRESET_RST  12'sh000
`define COS_MV_MIN      12'shFCE
`define COS_MV_MAX      12'sh41A
`define COS_MV_FULL     12'sh3E8
`define COS_SLEW_MAX    11'h3E8
`define COS_FRAC_ONE    11'h3E8
// ****************************************************************
// Timing
// ****************************************************************
`define COS_CLK_NS      10
`define COS_TICK_NS     1000000
`define COS_MS_PER_S    1000
`define COS_BLINK_MS    500
`endif

//--- design/cos_pkg.sv
// Types shared by the control output stage
package cos_pkg;
    typedef logic signed [11:0] cos_mv_t;
    typedef enum logic [1:0] {COS_BSEL_OFF, COS_BSEL_UP, COS_BSEL_DOWN} cos_bsel_t;
    typedef enum logic [1:0] {COS_ROUTE_OUT1, COS_ROUTE_OUT2, COS_ROUTE_EV1} cos_route_t;
endpackage

//--- design/cos_pwm.sv
// Time-proportioning generator for relay and SSR drive
`timescale 1ns/1ps
`include "cos_defs.svh"
module cos_pwm (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Timing and setting
    input  wire logic             tick,
    input  wire logic [7:0]       period_s,
    input  wire cos_pkg::cos_mv_t duty,
    input  wire logic             pulse_mode,
    // Drive
    output logic                  pulse_reg
);
    import cos_pkg::*;

    logic [17:0] cnt_reg;
    logic [17:0] period_ms;
    logic [17:0] on_ms;
    logic [9:0]  duty_pos;

    // Duty is clipped to 0..100 %, so the on time never exceeds one period
    always_comb begin
        if (duty < 12'sh000) begin
            duty_pos = 10'h000;
        end else if (duty > `COS_MV_FULL) begin
            duty_pos = 10'h3E8;
        end else begin
            duty_pos = duty[9:0];
        end
        period_ms = 18'(period_s * 18'(`COS_MS_PER_S));
        on_ms     = 18'(duty_pos) * 18'(period_s); // Widened first so a full duty at long periods cannot wrap
    end

    // Millisecond counter over one whole on-plus-off period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 18'h00000;
        end else if (tick) begin
            cnt_reg <= (cnt_reg >= period_ms - 18'h00001) ? 18'h00000 : cnt_reg + 18'h00001;
        end
    end

    // On for the leading duty fraction of the period; idle when not pulsing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= pulse_mode && (cnt_reg < on_ms);
        end
    end

    pwm_on_frac_a: assert property (@(posedge clk) disable iff (!rst_n)
        pulse_reg |-> $past(cnt_reg) < $past(on_ms))
        else $error("pulse on outside its on time");
    pwm_scr_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pulse_mode |=> !pulse_reg)
        else $error("pulse active while cycle period not applicable");
endmodule

//--- design/cos_top.sv
// Control output stage: direction, limits, slew, preset output, proportioning and lamp
// Summary of operation
// - Reverse action default; forward action mirrors drive about 50 percent.
// - Relay/SSR output on for MV fraction of each on-plus-off cycle period, default 2 s.
// - Cycle period used only for SSR or relay; SCR drive ignores it.
// - MV clamped to low..high limits within -5.0..105.0 percent, high above low.
// - Nonzero slew rate 0.1..100.0 percent per second limits MV movement; zero is off.
// - Stop, converter error or burn-out drive the preset value, -5.0..105.0 percent.
// - SSR lamp mode follows the pulse output; SCR mode blinks on its own.
// - Burn-out forces preset only when burn-out detection is up or down scale.
// - Drive routes to analog output 1, 2 or event relay; SCR only on analog.
`timescale 1ns/1ps
`include "cos_defs.svh"
module cos_top #(
    parameter int unsigned TICK_CYCLES = `COS_TICK_NS / `COS_CLK_NS
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Controller inputs
    input  wire cos_pkg::cos_mv_t manipulated_value,
    input  wire logic             ctl_stop,
    input  wire logic             adc_error,
    input  wire logic             sensor_burnout,
    // Actuator and lamp drives
    output logic                  out1_drive,
    output logic                  out2_drive,
    output logic                  ev1_drive,
    output cos_pkg::cos_mv_t      scr_level,
    output logic                  out_lamp
);
    import cos_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    // ****************************************************************
    // Settings and state
    // ****************************************************************
    logic [7:0]  ctrl_reg;
    logic [7:0]  cycle_period;
    cos_mv_t     mv_high_limit;
    cos_mv_t     mv_low_limit;
    logic [10:0] mv_slew_rate;
    cos_mv_t     preset_output_value;
    cos_mv_t     mv_reg;
    logic [10:0] frac_reg;
    logic [TW-1:0] tick_cnt;
    logic        tick;
    logic [8:0]  blink_cnt;
    logic        blink_reg;
    logic        pulse;
    logic        fault;
    logic        scr_mode;
    logic        fwd;
    logic        lamp_scr;
    cos_bsel_t   burnout_select;
    cos_route_t  route;
    cos_mv_t     dir_mv;
    cos_mv_t     target;
    cos_mv_t     wval;
    logic [10:0] frac_sum;
    logic        wr_en;

    assign fwd            = ctrl_reg[`COS_CTRL_DIR];
    assign lamp_scr       = ctrl_reg[`COS_CTRL_LAMP];
    assign burnout_select = cos_bsel_t'(ctrl_reg[`COS_CTRL_BSEL +: 2]);
    assign route          = cos_route_t'(ctrl_reg[`COS_CTRL_ROUTE +: 2]);
    // Event relay is always pulse driven, whatever the heat type says
    assign scr_mode       = ctrl_reg[`COS_CTRL_SCR] && (route != COS_ROUTE_EV1);
    assign wval           = pwdata[11:0];
    assign wr_en          = psel && penable && pready && pwrite;

    // ****************************************************************
    // Millisecond tick and lamp blink
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Blink timing is free running on the tick and is not restarted by the cycle period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt <= 9'h000;
            blink_reg <= 1'b0;
        end else if (tick) begin
            if (blink_cnt == 9'(`COS_BLINK_MS - 1)) begin
                blink_cnt <= 9'h000;
                blink_reg <= !blink_reg;
            end else begin
                blink_cnt <= blink_cnt + 9'h001;
            end
        end
    end

    // ****************************************************************
    // Target MV: direction, then limits, emergency detection
    // ****************************************************************
    always_comb begin
        dir_mv = fwd ? cos_mv_t'(`COS_MV_FULL - manipulated_value) : manipulated_value;
        if (dir_mv > mv_high_limit) begin
            target = mv_high_limit;
        end else if (dir_mv < mv_low_limit) begin
            target = mv_low_limit;
        end else begin
            target = dir_mv;
        end
        fault    = ctl_stop || adc_error || (sensor_burnout && burnout_select != COS_BSEL_OFF);
        frac_sum = frac_reg + mv_slew_rate;
    end

    // Slew limiter: rate is in thousandths of a step per ms, so at most one step per tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv_reg   <= `COS_PRESET_RST;
            frac_reg <= 11'h000;
        end else if (fault) begin
            mv_reg   <= preset_output_value;
            frac_reg <= 11'h000;
        end else if (mv_slew_rate == 11'h000) begin
            mv_reg   <= target;
            frac_reg <= 11'h000;
        end else if (tick) begin
            if (mv_reg == target) begin
                frac_reg <= 11'h000;
            end else if (frac_sum >= `COS_FRAC_ONE) begin
                mv_reg   <= (target > mv_reg) ? mv_reg + 12'sh001 : mv_reg - 12'sh001;
                frac_reg <= frac_sum - `COS_FRAC_ONE;
            end else begin
                frac_reg <= frac_sum;
            end
        end
    end

    // ****************************************************************
    // Proportioning and output routing
    // ****************************************************************
    cos_pwm u_pwm (
        .clk        (pclk),
        .rst_n      (presetn),
        .tick       (tick),
        .period_s   (cycle_period),
        .duty       (mv_reg),
        .pulse_mode (!scr_mode),
        .pulse_reg  (pulse)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out1_drive <= 1'b0;
            out2_drive <= 1'b0;
            ev1_drive  <= 1'b0;
            scr_level  <= 12'sh000;
            out_lamp   <= 1'b0;
        end else begin
            out1_drive <= pulse && (route == COS_ROUTE_OUT1);
            out2_drive <= pulse && (route == COS_ROUTE_OUT2);
            ev1_drive  <= pulse && (route == COS_ROUTE_EV1);
            scr_level  <= scr_mode ? mv_reg : 12'sh000;
            out_lamp   <= lamp_scr ? blink_reg : pulse;
        end
    end

    // ****************************************************************
    // APB registers; bad settings are dropped so limits stay ordered
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg            <= `COS_CTRL_RST;
            cycle_period        <= `COS_CYCLE_RST;
            mv_high_limit       <= `COS_HIGH_RST;
            mv_low_limit        <= `COS_LOW_RST;
            mv_slew_rate        <= `COS_SLEW_RST;
            preset_output_value <= `COS_PRESET_RST;
        end else if (wr_en) begin
            unique case (paddr)
                `COS_CTRL_OFS: begin
                    if (pwdata[`COS_CTRL_BSEL +: 2] != 2'h3 && pwdata[`COS_CTRL_ROUTE +: 2] != 2'h3) begin
                        ctrl_reg <= pwdata[7:0];
                    end
                end
                `COS_CYCLE_OFS: begin
                    if (pwdata[7:0] != 8'h00) begin
                        cycle_period <= pwdata[7:0];
                    end
                end
                `COS_HIGH_OFS: begin
                    if (wval > mv_low_limit && wval <= `COS_MV_MAX) begin
                        mv_high_limit <= wval;
                    end
                end
                `COS_LOW_OFS: begin
                    if (wval >= `COS_MV_MIN && wval < mv_high_limit) begin
                        mv_low_limit <= wval;
                    end
                end
                `COS_SLEW_OFS: begin
                    if (pwdata[31:0] <= 32'(`COS_SLEW_MAX)) begin
                        mv_slew_rate <= pwdata[10:0];
                    end
                end
                `COS_PRESET_OFS: begin
                    if (wval >= `COS_MV_MIN && wval <= `COS_MV_MAX) begin
                        preset_output_value <= wval;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is fetched in the setup cycle so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (psel && !penable) begin
                unique case (paddr)
                    `COS_CTRL_OFS:   prdata <= {24'h000000, ctrl_reg};
                    `COS_CYCLE_OFS:  prdata <= {24'h000000, cycle_period};
                    `COS_HIGH_OFS:   prdata <= {20'h00000, mv_high_limit};
                    `COS_LOW_OFS:    prdata <= {20'h00000, mv_low_limit};
                    `COS_SLEW_OFS:   prdata <= {21'h000000, mv_slew_rate};
                    `COS_PRESET_OFS: prdata <= {20'h00000, preset_output_value};
                    `COS_STATUS_OFS: prdata <= {14'h0000, fault, pulse, 4'h0, mv_reg};
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    dir_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fault && mv_slew_rate == 11'h000 && fwd && manipulated_value == 12'sh12C
        && mv_low_limit <= 12'sh2BC && mv_high_limit >= 12'sh2BC
        |=> mv_reg == 12'sh2BC)
        else $error("forward action did not mirror the drive");
    limit_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        mv_low_limit < mv_high_limit && mv_low_limit >= `COS_MV_MIN && mv_high_limit <= `COS_MV_MAX)
        else $error("output limits out of order or range");
    clamp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fault && mv_slew_rate == 11'h000 && $stable(mv_low_limit) && $stable(mv_high_limit)
        |=> mv_reg <= $past(mv_high_limit) && mv_reg >= $past(mv_low_limit))
        else $error("MV outside its limits");
    slew_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        !fault && mv_slew_rate != 11'h000 && !$past(fault)
        |-> (mv_reg - $past(mv_reg) <= 12'sh001) && ($past(mv_reg) - mv_reg <= 12'sh001))
        else $error("MV moved faster than the slew limit");
    slew_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tick && !fault && mv_slew_rate != 11'h000 && $stable(mv_slew_rate) |=> $stable(mv_reg))
        else $error("slew-limited MV moved without a tick");
    preset_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_stop ##1 ctl_stop |-> mv_reg == $past(preset_output_value))
        else $error("stop did not force the preset output");
    burnout_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        sensor_burnout && burnout_select == COS_BSEL_OFF && !ctl_stop && !adc_error && mv_slew_rate == 11'h000
        |=> mv_reg == $past(target))
        else $error("burn-out forced preset with detection off");
    lamp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !lamp_scr |=> out_lamp == $past(pulse))
        else $error("lamp does not follow the pulse output");
    tick_space_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick)
        else $error("millisecond tick repeated back to back");
endmodule

//--- test/cos_heater.sv
// Heater-side actuator model that times how long each drive holds its load on
`timescale 1ns/1ps
module cos_heater (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Drives arriving from the output stage
    input  wire logic        out1_drive,
    input  wire logic        out2_drive,
    input  wire logic        ev1_drive,
    input  wire logic        out_lamp,
    // Window control from the bench
    input  wire logic        clear,
    // On-time of each load in clock cycles
    output logic [31:0]      out1_on,
    output logic [31:0]      out2_on,
    output logic [31:0]      ev1_on,
    output logic [31:0]      lamp_on
);
    // ****************************************************************
    // On-time integration
    // ****************************************************************
    // Counting whole cycles keeps the duty exact over one full period window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out1_on <= 32'h0;
            out2_on <= 32'h0;
            ev1_on  <= 32'h0;
            lamp_on <= 32'h0;
        end else if (clear) begin
            out1_on <= 32'h0;
            out2_on <= 32'h0;
            ev1_on  <= 32'h0;
            lamp_on <= 32'h0;
        end else begin
            out1_on <= out1_on + 32'(out1_drive);
            out2_on <= out2_on + 32'(out2_drive);
            ev1_on  <= ev1_on + 32'(ev1_drive);
            lamp_on <= lamp_on + 32'(out_lamp);
        end
    end
endmodule

//--- test/control_output_stage_tb.sv
// Self-checking bench of the control output stage over its register bus
`timescale 1ns/1ps
`include "cos_defs.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module control_output_stage_tb;
    import cos_pkg::*;
    localparam int TICK = 10;
    localparam int WIN  = 1000 * TICK;
    localparam int LIMIT = 80000;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    cos_mv_t          mv, scr_level;
    logic             ctl_stop, adc_error, burnout, err, clear;
    logic             out1, out2, ev1, lamp;
    logic [31:0]      on1, on2, onev, onl;
    int               failures, n_compared, cycles;
    logic [11:0]      ofs [6];
    logic [31:0]      rst_val [6];
    cos_top #(.TICK_CYCLES(TICK)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manipulated_value(mv), .ctl_stop(ctl_stop), .adc_error(adc_error),
        .sensor_burnout(burnout), .out1_drive(out1), .out2_drive(out2), .ev1_drive(ev1),
        .scr_level(scr_level), .out_lamp(lamp));
    cos_heater u_heater (.pclk(pclk), .presetn(presetn), .out1_drive(out1), .out2_drive(out2),
        .ev1_drive(ev1), .out_lamp(lamp), .clear(clear), .out1_on(on1), .out2_on(on2),
        .ev1_on(onev), .lamp_on(onl));
    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // A stuck handshake or window would otherwise run forever
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            test_done();
        end
    end
    // ****************************************************************
    // Bus and measurement tasks
    // ****************************************************************
    // One APB transfer; request held until pready is sampled high, only the hang guard ends a wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read the live output value and fault flag after the pipeline settles
    task automatic chk_status(input logic [11:0] exp_mv, input logic exp_fault);
        repeat (4) @(posedge pclk);
        apb(1'b0, `COS_STATUS_OFS, 32'h0);
        `CHK("status mv", exp_mv, rd[11:0])
        `CHK("status fault", exp_fault, rd[`COS_STAT_FAULT])
    endtask
    // Integrate every drive over exactly one 1 s period
    task automatic window();
        repeat (20) @(posedge pclk);
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        repeat (WIN) @(posedge pclk);
        #1;
    endtask
    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic test_done();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, clear, ctl_stop, adc_error, burnout} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        mv = 12'sh000;
        presetn = 1'b0;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        ofs = '{`COS_CTRL_OFS, `COS_CYCLE_OFS, `COS_HIGH_OFS, `COS_LOW_OFS, `COS_SLEW_OFS, `COS_PRESET_OFS};
        rst_val = '{{24'h0, `COS_CTRL_RST}, {24'h0, `COS_CYCLE_RST}, {20'h0, `COS_HIGH_RST},
                    {20'h0, `COS_LOW_RST}, {21'h0, `COS_SLEW_RST}, {20'h0, `COS_PRESET_RST}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Shorter period chosen only to keep runs brief; 30 s relay / 2 s SSR is advice
        apb(1'b1, `COS_CYCLE_OFS, 32'h1);
        apb(1'b1, `COS_CYCLE_OFS, 32'h0);
        apb(1'b0, `COS_CYCLE_OFS, 32'h0);
        `CHK("cycle zero ignored", 32'h1, rd)
        for (int i = 2; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            `CHK("reset value", rst_val[i], rd)
        end
        apb(1'b0, `COS_CTRL_OFS, 32'h0);
        `CHK("ctrl reset", rst_val[0], rd)
        apb(1'b1, `COS_CTRL_OFS, 32'h30);
        apb(1'b0, `COS_CTRL_OFS, 32'h0);
        `CHK("ctrl bad select", 32'h10, rd)
        apb(1'b0, 12'h01C, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        end_test("reset");
        // Limits: out-of-range settings refused, MV clamped both ways
        apb(1'b1, `COS_HIGH_OFS, 32'd1051);
        apb(1'b0, `COS_HIGH_OFS, 32'h0);
        `CHK("high over range", 32'h3E8, rd)
        apb(1'b1, `COS_HIGH_OFS, 32'd800);
        apb(1'b1, `COS_LOW_OFS, 32'd800);
        apb(1'b1, `COS_LOW_OFS, 32'd100);
        apb(1'b0, `COS_LOW_OFS, 32'h0);
        `CHK("low below high", 32'd100, rd)
        mv <= 12'sd900;
        chk_status(12'd800, 1'b0);
        mv <= 12'sd50;
        chk_status(12'd100, 1'b0);
        // Forward action mirrors the demand
        apb(1'b1, `COS_CTRL_OFS, 32'h11);
        mv <= 12'sd300;
        chk_status(12'd700, 1'b0);
        apb(1'b1, `COS_CTRL_OFS, 32'h10);
        chk_status(12'd300, 1'b0);
        apb(1'b1, `COS_LOW_OFS, 32'd0);
        apb(1'b1, `COS_HIGH_OFS, 32'd1000);
        end_test("limits and direction");
        // Preset output on stop, converter error and burn-out per detection mode
        apb(1'b1, `COS_PRESET_OFS, 32'h0000_0FCE);
        mv <= 12'sd250;
        ctl_stop <= 1'b1;
        chk_status(`COS_MV_MIN, 1'b1);
        ctl_stop <= 1'b0;
        adc_error <= 1'b1;
        chk_status(`COS_MV_MIN, 1'b1);
        adc_error <= 1'b0;
        burnout <= 1'b1;
        for (int b = 0; b < 3; b++) begin
            apb(1'b1, `COS_CTRL_OFS, 32'(b << `COS_CTRL_BSEL));
            chk_status((b == 0) ? 12'd250 : `COS_MV_MIN, b != 0);
        end
        burnout <= 1'b0;
        apb(1'b1, `COS_CTRL_OFS, 32'h10);
        chk_status(12'd250, 1'b0);
        end_test("preset output");
        // Proportioning on each route; lamp follows the pulse in SSR lamp mode
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, `COS_CTRL_OFS, 32'h10 | 32'(r << `COS_CTRL_ROUTE));
            window();
            `CHK("out1 on", (r == 0) ? 32'd2500 : 32'd0, on1)
            `CHK("out2 on", (r == 1) ? 32'd2500 : 32'd0, on2)
            `CHK("ev1 on", (r == 2) ? 32'd2500 : 32'd0, onev)
            `CHK("lamp on", 32'd2500, onl)
        end
        // SCR drive ignores the period and the lamp blinks half the time
        apb(1'b1, `COS_CTRL_OFS, 32'h16);
        window();
        `CHK("scr no pulse", 32'd0, on1)
        `CHK("scr lamp blink", 32'd5000, onl)
        `CHK("scr level", 12'sd250, scr_level)
        end_test("proportioning");
        // Slew at 100 %/s: one step of 0.1 % per millisecond
        apb(1'b1, `COS_CTRL_OFS, 32'h10);
        mv <= 12'sd0;
        chk_status(12'd0, 1'b0);
        apb(1'b1, `COS_SLEW_OFS, 32'd1001);
        apb(1'b1, `COS_SLEW_OFS, 32'd1000);
        apb(1'b0, `COS_SLEW_OFS, 32'h0);
        `CHK("slew readback", 32'd1000, rd)
        mv <= 12'sd100;
        repeat (50 * TICK) @(posedge pclk);
        apb(1'b0, `COS_STATUS_OFS, 32'h0);
        `CHK("slew midway", 1'b1, rd[11:0] >= 12'd40 && rd[11:0] <= 12'd60)
        repeat (100 * TICK) @(posedge pclk);
        chk_status(12'd100, 1'b0);
        end_test("slew");
        test_done();
    end
endmodule
